//--- hw/adrc_pkg.sv
// package for the axle distance rolling counter
// assumes a single 100 MHz clock and distance increments arriving in eighth-metre steps
`default_nettype none
package adrc_pkg;
  localparam int CNT_W = 13;
  localparam int STEP_W = 8;
  localparam logic [12:0] CNT_RST = 13'h0000;
  localparam int CLK_HZ = 100_000_000;
  localparam int HOLD_MS = 2000;
  localparam int HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
  localparam int HOLD_W = 32;
  // register map, one word each
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_HOLD = 8'h04;
  localparam logic [7:0] OFS_DRIVEN = 8'h08;
  localparam logic [7:0] OFS_NONDRV = 8'h0c;
  // ctrl bits
  localparam int CB_NET_ACT = 0;
  localparam int CB_MEM_RST = 1;
  localparam int CB_WHEEL_DRV = 2;
  // status bit positions above the count
  localparam int SB_VALID_N = 13;
  localparam int SB_RST_OCC = 14;
  localparam int SB_SRC = 15;
  localparam logic [31:0] CTRL_RST = 32'h0000_0004;
  typedef enum logic [1:0] {
    SRC_SHAFT = 2'b00,
    SRC_AVG = 2'b01,
    SRC_SINGLE = 2'b11,
    SRC_NONE = 2'b10
  } adrc_src_t;
endpackage : adrc_pkg
`default_nettype wire

//--- hw/adrc_top.sv
// rolling distance counters for driven and non-driven axles, apb slave for setup and readback
// assumes wheel and shaft inputs synchronous to pclk, each delta valid for one cycle
//
// Decided for this implementation: the register addresses and the APB register port.
`default_nettype none
module adrc_top #(
  parameter logic [31:0] HOLD_CYCLES = 32'(adrc_pkg::HOLD_CYC)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tick,
  input wire logic shaft_ok,
  input wire logic [7:0] shaft_delta,
  input wire logic abs_present,
  input wire logic drv_l_ok,
  input wire logic drv_r_ok,
  input wire logic [7:0] drv_l_delta,
  input wire logic [7:0] drv_r_delta,
  input wire logic nd_l_ok,
  input wire logic nd_r_ok,
  input wire logic [7:0] nd_l_delta,
  input wire logic [7:0] nd_r_delta,
  output logic [12:0] driven_count,
  output logic driven_invalid,
  output logic driven_src_wheel,
  output logic driven_reset_occ,
  output logic [12:0] nondrv_count,
  output logic nondrv_invalid,
  output logic nondrv_reset_occ
);
  logic [31:0] ctrl_r;
  logic [31:0] hold_r;
  logic net_seen_r;
  logic mem_req;
  logic both_restart;
  logic drv_prev_inv_r;
  logic nd_prev_inv_r;
  adrc_pkg::adrc_src_t drv_src;
  adrc_pkg::adrc_src_t nd_src;
  logic [7:0] drv_step;
  logic [7:0] nd_step;
  logic drv_restart;
  logic nd_restart;
  logic [31:0] drv_hold_r;
  logic [31:0] nd_hold_r;
  logic [12:0] drv_cnt_r;
  logic [12:0] nd_cnt_r;
  logic wr_en;
  logic rd_hit;

  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_hit = (paddr == adrc_pkg::OFS_CTRL) || (paddr == adrc_pkg::OFS_HOLD)
    || (paddr == adrc_pkg::OFS_DRIVEN) || (paddr == adrc_pkg::OFS_NONDRV);
  assign pslverr = psel && penable && !rd_hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= adrc_pkg::CTRL_RST;
      hold_r <= 32'h0000_0000;
    end
    else
    begin
      if (hold_r == 32'h0000_0000)
        hold_r <= HOLD_CYCLES;
      // memory reset bit is a one-shot; it self-clears
      ctrl_r[adrc_pkg::CB_MEM_RST] <= 1'b0;
      if (wr_en && paddr == adrc_pkg::OFS_CTRL)
        ctrl_r <= pwdata;
      if (wr_en && paddr == adrc_pkg::OFS_HOLD)
        hold_r <= (pwdata == 32'h0000_0000) ? 32'h0000_0001 : pwdata;
    end
  end

  always_comb
  begin
    prdata = 32'h0000_0000;
    case (paddr)
      adrc_pkg::OFS_CTRL: prdata = ctrl_r;
      adrc_pkg::OFS_HOLD: prdata = hold_r;
      adrc_pkg::OFS_DRIVEN: prdata = {16'h0000, driven_src_wheel, driven_reset_occ,
        driven_invalid, driven_count};
      adrc_pkg::OFS_NONDRV: prdata = {17'h00000, nondrv_reset_occ, nondrv_invalid,
        nondrv_count};
      default: prdata = 32'h0000_0000;
    endcase
  end

  // first rising of network activation restarts both counters once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      net_seen_r <= 1'b0;
    else if (ctrl_r[adrc_pkg::CB_NET_ACT])
      net_seen_r <= 1'b1;
  end
  assign mem_req = ctrl_r[adrc_pkg::CB_MEM_RST];
  assign both_restart = (ctrl_r[adrc_pkg::CB_NET_ACT] && !net_seen_r)
    || mem_req;

  // driven source choice; the primary axle is wired to the drv inputs by the integrator
  always_comb
  begin
    drv_src = adrc_pkg::SRC_NONE;
    drv_step = 8'h00;
    if (shaft_ok)
    begin
      drv_src = adrc_pkg::SRC_SHAFT;
      drv_step = shaft_delta;
    end
    else if (abs_present && ctrl_r[adrc_pkg::CB_WHEEL_DRV] && drv_l_ok && drv_r_ok)
    begin
      drv_src = adrc_pkg::SRC_AVG;
      drv_step = 8'((9'(drv_l_delta) + 9'(drv_r_delta)) >> 1);
    end
    else if (abs_present && (drv_l_ok ^ drv_r_ok))
    begin
      drv_src = adrc_pkg::SRC_SINGLE;
      drv_step = drv_l_ok ? drv_l_delta : drv_r_delta;
    end
    else if (drv_l_ok || drv_r_ok)
      drv_src = adrc_pkg::SRC_SINGLE;
  end

  always_comb
  begin
    nd_src = adrc_pkg::SRC_NONE;
    nd_step = 8'h00;
    if (!abs_present)
      nd_src = adrc_pkg::SRC_SHAFT;
    else if (nd_l_ok && nd_r_ok)
    begin
      nd_src = adrc_pkg::SRC_AVG;
      nd_step = 8'((9'(nd_l_delta) + 9'(nd_r_delta)) >> 1);
    end
    else if (nd_l_ok ^ nd_r_ok)
    begin
      nd_src = adrc_pkg::SRC_SINGLE;
      nd_step = nd_l_ok ? nd_l_delta : nd_r_delta;
    end
  end

  assign driven_invalid = (drv_src == adrc_pkg::SRC_NONE);
  assign nondrv_invalid = (nd_src == adrc_pkg::SRC_NONE);
  assign driven_src_wheel = (drv_src != adrc_pkg::SRC_SHAFT);
  assign drv_restart = both_restart || (drv_prev_inv_r && !driven_invalid);
  assign nd_restart = both_restart || (nd_prev_inv_r && !nondrv_invalid);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drv_prev_inv_r <= 1'b0;
      nd_prev_inv_r <= 1'b0;
    end
    else
    begin
      drv_prev_inv_r <= driven_invalid;
      nd_prev_inv_r <= nondrv_invalid;
    end
  end

  // natural 13-bit overflow keeps the excess past 1023.875 m
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drv_cnt_r <= adrc_pkg::CNT_RST;
      nd_cnt_r <= adrc_pkg::CNT_RST;
    end
    else
    begin
      if (drv_restart)
        drv_cnt_r <= adrc_pkg::CNT_RST;
      else if (tick && !driven_invalid)
        drv_cnt_r <= drv_cnt_r + 13'(drv_step);
      if (nd_restart || !abs_present)
        nd_cnt_r <= adrc_pkg::CNT_RST;
      else if (tick && !nondrv_invalid)
        nd_cnt_r <= nd_cnt_r + 13'(nd_step);
    end
  end
  assign driven_count = drv_cnt_r;
  assign nondrv_count = nd_cnt_r;

  // hold counters: flag stays true while counting goes on as normal
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drv_hold_r <= 32'h0000_0000;
      nd_hold_r <= 32'h0000_0000;
    end
    else
    begin
      if (drv_restart)
        drv_hold_r <= hold_r;
      else if (drv_hold_r != 32'h0000_0000)
        drv_hold_r <= drv_hold_r - 32'h0000_0001;
      if (nd_restart)
        nd_hold_r <= hold_r;
      else if (nd_hold_r != 32'h0000_0000)
        nd_hold_r <= nd_hold_r - 32'h0000_0001;
    end
  end
  assign driven_reset_occ = (drv_hold_r != 32'h0000_0000);
  assign nondrv_reset_occ = (nd_hold_r != 32'h0000_0000);

  property p_drv_invalid;
    @(posedge pclk) disable iff (!presetn)
      (!shaft_ok && !drv_l_ok && !drv_r_ok) |-> driven_invalid;
  endproperty
  a_drv_invalid: assert property (p_drv_invalid) else $error("driven validity wrong");

  property p_src;
    @(posedge pclk) disable iff (!presetn) shaft_ok |-> !driven_src_wheel;
  endproperty
  a_src: assert property (p_src) else $error("source flag wrong");

  property p_drv_recover;
    @(posedge pclk) disable iff (!presetn)
      ($past(driven_invalid) && !driven_invalid && hold_r > 1) |=> drv_cnt_r == 13'h0000
        && driven_reset_occ;
  endproperty
  a_drv_recover: assert property (p_drv_recover) else $error("driven restart missing");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      ($rose(driven_reset_occ) && hold_r > 2) |=> driven_reset_occ[*2];
  endproperty
  a_hold: assert property (p_hold) else $error("reset flag dropped early");

  property p_nd_zero;
    @(posedge pclk) disable iff (!presetn)
      !abs_present |=> (nd_cnt_r == 13'h0000 || abs_present);
  endproperty
  a_nd_zero: assert property (p_nd_zero) else $error("non-driven not zero");

  property p_nd_valid;
    @(posedge pclk) disable iff (!presetn)
      (nd_l_ok || nd_r_ok || !abs_present) |-> !nondrv_invalid;
  endproperty
  a_nd_valid: assert property (p_nd_valid) else $error("non-driven validity wrong");

  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
      (tick && !drv_restart && !driven_invalid) |=>
        drv_cnt_r == $past(drv_cnt_r) + 13'($past(drv_step));
  endproperty
  a_wrap: assert property (p_wrap) else $error("driven count not wrapping");

  property p_mem;
    @(posedge pclk) disable iff (!presetn)
      (mem_req && hold_r > 1) |=> driven_reset_occ && nondrv_reset_occ && drv_cnt_r == 13'h0000;
  endproperty
  a_mem: assert property (p_mem) else $error("memory reset not seen");

  property p_avg;
    @(posedge pclk) disable iff (!presetn)
      (!shaft_ok && abs_present && ctrl_r[adrc_pkg::CB_WHEEL_DRV] && drv_l_ok && drv_r_ok)
        |-> 10'(drv_step) * 10'h002 <= 10'(drv_l_delta) + 10'(drv_r_delta)
        && 10'(drv_l_delta) + 10'(drv_r_delta) <= 10'(drv_step) * 10'h002 + 10'h001;
  endproperty
  a_avg: assert property (p_avg) else $error("driven average wrong");

  property p_single;
    @(posedge pclk) disable iff (!presetn)
      (!shaft_ok && abs_present && !drv_l_ok && drv_r_ok)
        |-> drv_step == drv_r_delta && !driven_invalid && driven_src_wheel;
  endproperty
  a_single: assert property (p_single) else $error("driven single wheel wrong");

  property p_nd_avg;
    @(posedge pclk) disable iff (!presetn)
      (abs_present && nd_l_ok && nd_r_ok)
        |-> 10'(nd_step) * 10'h002 <= 10'(nd_l_delta) + 10'(nd_r_delta)
        && 10'(nd_l_delta) + 10'(nd_r_delta) <= 10'(nd_step) * 10'h002 + 10'h001;
  endproperty
  a_nd_avg: assert property (p_nd_avg) else $error("non-driven average wrong");

  property p_nd_single;
    @(posedge pclk) disable iff (!presetn)
      (abs_present && nd_l_ok && !nd_r_ok)
        |-> nd_step == nd_l_delta && !nondrv_invalid;
  endproperty
  a_nd_single: assert property (p_nd_single) else $error("non-driven single wrong");

  property p_nd_recover;
    @(posedge pclk) disable iff (!presetn)
      ($past(nondrv_invalid) && !nondrv_invalid && hold_r > 1)
        |=> nd_cnt_r == 13'h0000 && nondrv_reset_occ;
  endproperty
  a_nd_recover: assert property (p_nd_recover) else $error("non-driven restart missing");

  property p_net;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_r[adrc_pkg::CB_NET_ACT] && !net_seen_r && hold_r > 1)
        |=> drv_cnt_r == 13'h0000 && nd_cnt_r == 13'h0000
        && driven_reset_occ && nondrv_reset_occ;
  endproperty
  a_net: assert property (p_net) else $error("network start restart missing");

  property p_drv_fall;
    @(posedge pclk) disable iff (!presetn)
      $fell(driven_reset_occ) |-> $past(drv_hold_r) == 32'h0000_0001;
  endproperty
  a_drv_fall: assert property (p_drv_fall) else $error("driven flag dropped early");

  property p_nd_fall;
    @(posedge pclk) disable iff (!presetn)
      $fell(nondrv_reset_occ) |-> $past(nd_hold_r) == 32'h0000_0001;
  endproperty
  a_nd_fall: assert property (p_nd_fall) else $error("non-driven flag dropped early");
endmodule : adrc_top
`default_nettype wire

//--- verif/adrc_rx_model.sv
// gateway-side receiver that adds up driven-axle distance
// assumes counts and flags synchronous to pclk
`default_nettype none
module adrc_rx_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [12:0] cnt,
  input wire logic invalid,
  input wire logic reset_occ,
  output logic [31:0] total
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] last_r;
  logic occ_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_r <= 13'h0000;
      occ_r <= 1'b0;
      total <= 32'h0000_0000;
    end
    else
    begin
      occ_r <= reset_occ;
      if (!invalid)
      begin
        last_r <= cnt;
        // only the rising edge restarts, so a held flag is not taken twice
        if (reset_occ && !occ_r)
          total <= total + 32'(cnt);
        else
          total <= total + 32'(13'(cnt - last_r));
      end
    end
  end
endmodule : adrc_rx_model
`default_nettype wire

//--- verif/tb_adrc_top.sv
// self-checking bench for the axle distance rolling counter
// assumes zero-wait apb and a reset-occurred hold of 20 cycles
`default_nettype none
module tb_adrc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tick = 1'b0;
  logic shaft_ok = 1'b1, abs_present = 1'b1, drv_l_ok = 1'b1, drv_r_ok = 1'b1;
  logic nd_l_ok = 1'b1, nd_r_ok = 1'b1, pready, pslverr, err;
  logic [7:0] paddr = 8'h00, shaft_delta = 8'h10, drv_l_delta = 8'h20, drv_r_delta = 8'h30;
  logic [7:0] nd_l_delta = 8'h05, nd_r_delta = 8'h07;
  logic [31:0] pwdata = 32'h0, prdata, total, t0, rd;
  logic driven_invalid, driven_src_wheel, driven_reset_occ, nondrv_invalid, nondrv_reset_occ;
  logic [12:0] driven_count, nondrv_count;
  int num_errors = 0;
  int n_compared = 0;
  int n, m;
  always #5 pclk = ~pclk;
  adrc_top #(.HOLD_CYCLES(32'h14)) i_adrc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .tick, .shaft_ok, .shaft_delta, .abs_present, .drv_l_ok,
    .drv_r_ok, .drv_l_delta, .drv_r_delta, .nd_l_ok, .nd_r_ok, .nd_l_delta, .nd_r_delta,
    .driven_count, .driven_invalid, .driven_src_wheel, .driven_reset_occ, .nondrv_count,
    .nondrv_invalid, .nondrv_reset_occ);
  adrc_rx_model i_adrc_rx_model (.pclk, .presetn, .cnt(driven_count), .invalid(driven_invalid),
    .reset_occ(driven_reset_occ), .total);
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && i < 50)
    begin
      @(posedge pclk);
      i++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so a following request never re-drives psel in this time step
    @(posedge pclk);
    if (i == 50)
    begin
      num_errors++;
      results();
    end
  endtask : apb
  task automatic step;
    tick <= 1'b1;
    @(posedge pclk);
    tick <= 1'b0;
    @(posedge pclk);
  endtask : step
  // window is wider than the hold, so n and m are the full high times
  task automatic occ_len;
    n = 0;
    m = 0;
    repeat (100)
    begin
      @(posedge pclk);
      n += int'(driven_reset_occ === 1'b1);
      m += int'(nondrv_reset_occ === 1'b1);
    end
  endtask : occ_len
  task automatic t_regs;
    apb(1'b0, adrc_pkg::OFS_CTRL, 32'h0);
    chk(rd, adrc_pkg::CTRL_RST);
    apb(1'b1, adrc_pkg::OFS_HOLD, 32'h14);
    apb(1'b0, adrc_pkg::OFS_HOLD, 32'h0);
    chk(rd, 32'h14);
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("test regs done");
  endtask : t_regs
  task automatic t_restart(input logic [31:0] exp_len);
    occ_len();
    chk(32'(n), exp_len);
    chk(32'(m), exp_len);
    chk(32'({driven_count, nondrv_count}), 32'h0);
  endtask : t_restart
  task automatic t_sources;
    step();
    chk(32'({driven_src_wheel, driven_count}), 32'h10);
    chk(32'(nondrv_count), 32'h6);
    shaft_ok <= 1'b0;
    step();
    chk(32'({driven_src_wheel, driven_count}), 32'h2038);
    // wheel config without driven wheels: no average, still valid, no step
    apb(1'b1, adrc_pkg::OFS_CTRL, 32'h1);
    step();
    chk(32'({driven_invalid, driven_src_wheel, driven_count}), 32'h2038);
    apb(1'b1, adrc_pkg::OFS_CTRL, 32'h5);
    drv_l_ok <= 1'b0;
    nd_r_ok <= 1'b0;
    step();
    chk(32'({driven_invalid, driven_src_wheel, driven_count}), 32'h2068);
    chk(32'({nondrv_invalid, nondrv_count}), 32'h17);
    apb(1'b0, adrc_pkg::OFS_DRIVEN, 32'h0);
    chk(rd, 32'h8068);
    apb(1'b0, adrc_pkg::OFS_NONDRV, 32'h0);
    chk(rd, 32'h17);
    $display("test sources done");
  endtask : t_sources
  task automatic t_invalid;
    drv_r_ok <= 1'b0;
    nd_l_ok <= 1'b0;
    @(posedge pclk);
    chk(32'({driven_invalid, nondrv_invalid}), 32'h3);
    drv_l_ok <= 1'b1;
    nd_l_ok <= 1'b1;
    t_restart(32'h14);
    chk(32'({driven_invalid, nondrv_invalid}), 32'h0);
    $display("test invalid done");
  endtask : t_invalid
  task automatic t_wrap;
    shaft_ok <= 1'b1;
    shaft_delta <= 8'hff;
    nd_l_delta <= 8'hff;
    nd_r_delta <= 8'hff;
    t0 = total;
    repeat (40) step();
    chk(32'(driven_count), 32'h7d8);
    chk(32'(nondrv_count), 32'h7d8);
    // the receiver takes each count one cycle after it stands
    @(posedge pclk);
    chk(total - t0, 32'h27d8);
    $display("test wrap done");
  endtask : t_wrap
  task automatic t_noabs;
    abs_present <= 1'b0;
    step();
    chk(32'({nondrv_invalid, nondrv_count}), 32'h0);
    apb(1'b1, adrc_pkg::OFS_CTRL, 32'h7);
    t_restart(32'h14);
    $display("test noabs done");
  endtask : t_noabs
  task automatic t_netact;
    apb(1'b1, adrc_pkg::OFS_CTRL, 32'h5);
    t_restart(32'h14);
    $display("test netact done");
  endtask : t_netact
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_netact();
    t_sources();
    t_invalid();
    t_wrap();
    t_noabs();
    results();
  end
endmodule : tb_adrc_top
`default_nettype wire
